// *** bench/cs_i2c_master.sv ***
/*
  Bus master model for the two-wire slave: start, stop and byte transfers at 80 ns per bit.
  Assumes no clock stretching; SDA is open drain with its pull-up resolved here.
*/
module cs_i2c_master (
  // Device pull on the shared data wire
  input  wire logic dev_oe,
  // Bus lines
  output logic      scl,
  output wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;

  logic m_low;

  // Pull-up wins unless someone pulls low
  assign sda = !(m_low || dev_oe);

  initial begin
    scl = 1'h1;
    m_low = 1'h0;
  end

  // Start or repeated start: SDA falls while SCL high
  task automatic start();
    m_low = 1'h0;
    #20 scl = 1'h1;
    #20 m_low = 1'h1;
    #20 scl = 1'h0;
    #20;
  endtask

  // Stop: SDA rises while SCL high
  task automatic stop();
    m_low = 1'h1;
    #20 scl = 1'h1;
    #20 m_low = 1'h0;
    #20;
  endtask

  // One bit; data changes only in the low phase, 40 ns low and 40 ns high
  task automatic bit_io(input logic b, output logic r);
    m_low = !b;
    #20 scl = 1'h1;
    #20 r = sda;
    #20 scl = 1'h0;
    #20;
  endtask

  // Byte MSB first, then the ninth bit; rel high leaves SDA to the device
  task automatic xfer(input logic [7:0] d, input logic rel, output logic [7:0] q, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(rel, s);
    ack = !s;
  endtask
endmodule // cs_i2c_master

// *** bench/cs_i2c_regs_checker.sv ***
/*
  Port checker for cs_i2c_regs, bound to every instance.
  Assumes SCL phases of at least 8 clk and a timer unit of at least 9 clk.
*/
module cs_regs_checker #(
  parameter AW = 16
) (
  // Clock and reset
  input wire logic          clk,
  input wire logic          rstn,
  // Serial pins
  input wire logic          scl_i,
  input wire logic          sda_o,
  input wire logic          sda_oe,
  // Core side
  input wire logic          comp_out1,
  input wire logic          comp_out2,
  input wire logic          adaptive_mode,
  input wire logic [1:0]    cap_range,
  input wire logic [AW-1:0] avg1,
  input wire logic          avg1_valid,
  input wire logic [AW-1:0] avg2,
  input wire logic          avg2_valid,
  input wire logic          offset_dac_on1,
  input wire logic          offset_dac_on2,
  input wire logic [5:0]    offset_code1,
  input wire logic [5:0]    offset_code2,
  input wire logic          power_down
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  ////////////////////////////////////////////////////////////////////////////////
  // Code expected after one tracking pulse; saturates at both ends
  function automatic logic [5:0] trk(input logic [5:0] c, input logic [AW-1:0] a, input logic [1:0] r);
    logic [6:0] s;
    s = {5'h00, r} + 7'h01;
    if (a > {2'h3, {(AW-2){1'h0}}}) trk = ({1'h0, c} + s > 7'h3f) ? 6'h3f : c + s[5:0];
    else if (a < {2'h1, {(AW-2){1'h0}}}) trk = ({1'h0, c} < s) ? 6'h00 : c - s[5:0];
    else trk = c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Steps: a comparator restart seen while awake, then one more awake cycle
  sequence s_restart;
    ($rose(comp_out1) || $rose(comp_out2)) && !power_down ##1 !power_down;
  endsequence

  property p_reset_vals;
    $rose(rstn) |-> offset_dac_on1 && offset_dac_on2 && offset_code1 == 6'h00 && offset_code2 == 6'h00 && !power_down;
  endproperty
  property p_dac_gate;
    offset_dac_on1 || offset_dac_on2 |-> !power_down;
  endproperty
  property p_restart;
    s_restart |=> !power_down [*8];
  endproperty
  // Wake lands one cycle after the address acknowledge starts driving SDA
  property p_wake;
    $fell(power_down) |-> $past(sda_oe) && !$past(sda_oe, 2);
  endproperty
  // A code change outside a bus write must come from one tracking pulse
  property p_trk1;
    $changed(offset_code1) && !$rose(sda_oe) |-> $past(avg1_valid && adaptive_mode && !power_down)
      && offset_code1 == trk($past(offset_code1), $past(avg1), $past(cap_range));
  endproperty
  property p_trk2;
    $changed(offset_code2) && !$rose(sda_oe) |-> $past(avg2_valid && adaptive_mode && !power_down)
      && offset_code2 == trk($past(offset_code2), $past(avg2), $past(cap_range));
  endproperty
  property p_oe_hold;
    $rose(sda_oe) |-> sda_oe [*8];
  endproperty
  // SDA may only move while SCL is low, else it would forge a start or stop
  property p_oe_low;
    $changed(sda_oe) |-> !scl_i && !$past(scl_i);
  endproperty
  property p_pull;
    sda_o == 1'h0;
  endproperty

  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");
  a_dac_gate: assert property (p_dac_gate) else $error("dac on while powered down");
  a_restart: assert property (p_restart) else $error("power down too soon after comparator");
  a_wake: assert property (p_wake) else $error("wake without address ack");
  a_trk1: assert property (p_trk1) else $error("channel 1 tracking wrong");
  a_trk2: assert property (p_trk2) else $error("channel 2 tracking wrong");
  a_oe_hold: assert property (p_oe_hold) else $error("sda drive too short");
  a_oe_low: assert property (p_oe_low) else $error("sda moved while scl high");
  a_pull: assert property (p_pull) else $error("sda pull value not low");
endmodule // cs_regs_checker

bind cs_i2c_regs cs_regs_checker #(.AW(AW)) u_cs_regs_checker (.clk(clk), .rstn(rstn), .scl_i(scl_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .comp_out1(comp_out1), .comp_out2(comp_out2), .adaptive_mode(adaptive_mode),
  .cap_range(cap_range), .avg1(avg1), .avg1_valid(avg1_valid), .avg2(avg2), .avg2_valid(avg2_valid),
  .offset_dac_on1(offset_dac_on1), .offset_dac_on2(offset_dac_on2), .offset_code1(offset_code1),
  .offset_code2(offset_code2), .power_down(power_down));

// *** bench/tb_top.sv ***
/*
  Self-checking bench for cs_i2c_regs: register rows, reset, tracking, address and timer tests.
  Assumes the design is built with a 20-cycle timer unit for simulation.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam [31:0] SN = 32'h89abcdef; // Arbitrary serial number
  localparam [7:0]  ID = 8'h3c;        // Arbitrary identity byte

  logic        clk = 1'h0, rstn = 1'h0, comp_out1 = 1'h0, comp_out2 = 1'h0, adaptive_mode = 1'h1;
  logic        avg1_valid = 1'h0, avg2_valid = 1'h0, k;
  logic [1:0]  cap_range = 2'h0;
  logic [15:0] avg1 = 16'h8000, avg2 = 16'h8000;
  logic [5:0]  e;
  logic [7:0]  q, rb [8];
  logic [7:0]  rv [8] = '{8'h40, 8'hc0, 8'hc0, SN[31:24], SN[23:16], SN[15:8], SN[7:0], ID};
  logic [23:0] rows [7] = '{24'h107f7f, 24'h113f3f, 24'h12c1c1, {16'h13ff, SN[31:24]}, {16'h1600, SN[7:0]},
                           {16'h1700, ID}, 24'h11e0e0};
  wire         scl, sda, sda_o, sda_oe, offset_dac_on1, offset_dac_on2, power_down;
  wire  [5:0]  offset_code1, offset_code2;
  int          fails = 0, checks_done = 0;

  always #2 clk = ~clk;

  cs_i2c_regs #(.SERIAL_NUMBER(SN), .CHIP_IDENT(ID), .UNIT_CYCLES(48'h14)) u_cs_i2c_regs (
    .clk(clk), .rstn(rstn), .ce(1'h1), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .comp_out1(comp_out1), .comp_out2(comp_out2), .adaptive_mode(adaptive_mode), .cap_range(cap_range),
    .avg1(avg1), .avg1_valid(avg1_valid), .avg2(avg2), .avg2_valid(avg2_valid),
    .offset_dac_on1(offset_dac_on1), .offset_dac_on2(offset_dac_on2), .offset_code1(offset_code1),
    .offset_code2(offset_code2), .power_down(power_down));

  cs_i2c_master u_cs_i2c_master (.dev_oe(sda_oe), .scl(scl), .sda(sda));

  ////////////////////////////////////////////////////////////////////////////////
  // Comparison, reporting and bus tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("Checks made %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_cs_i2c_master.start();
    u_cs_i2c_master.xfer(8'h90, 1'h1, q, k);
    chk({7'h0, k}, 8'h01);
    u_cs_i2c_master.xfer(a, 1'h1, q, k);
    u_cs_i2c_master.xfer(d, 1'h1, q, k);
    chk({7'h0, k}, 8'h01);
    u_cs_i2c_master.stop();
  endtask

  // Address 8'hff skips the pointer write and reads from where the pointer stands
  task automatic rd(input logic [7:0] a, input int n);
    if (a != 8'hff) begin
      u_cs_i2c_master.start();
      u_cs_i2c_master.xfer(8'h90, 1'h1, q, k);
      u_cs_i2c_master.xfer(a, 1'h1, q, k);
    end
    u_cs_i2c_master.start();
    u_cs_i2c_master.xfer(8'h91, 1'h1, q, k);
    chk({7'h0, k}, 8'h01);
    for (int i = 0; i < n; i++) u_cs_i2c_master.xfer(8'hff, 1'(i == n - 1), rb[i], k);
    u_cs_i2c_master.stop();
  endtask

  // One average pulse, then the resulting code
  task automatic trk(input logic ch, input logic [15:0] av, input logic md, input logic [1:0] rg,
                     input logic [5:0] x);
    @(negedge clk);
    adaptive_mode = md;
    cap_range = rg;
    avg1 = av;
    avg2 = av;
    avg1_valid = !ch;
    avg2_valid = ch;
    @(negedge clk);
    avg1_valid = 1'h0;
    avg2_valid = 1'h0;
    @(negedge clk);
    chk({2'h0, ch ? offset_code2 : offset_code1}, {2'h0, x});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (20) @(negedge clk);
    rstn = 1'h1;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 7; i++) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], 1);
      chk(rb[0], rows[i][7:0]);
      if (rows[i][23:16] == 8'h11) chk({offset_dac_on1, 1'h0, offset_code1}, {rows[i][15], 1'h0, rows[i][5:0]});
      if (rows[i][23:16] == 8'h12) chk({offset_dac_on2, 1'h0, offset_code2}, {rows[i][15], 1'h0, rows[i][5:0]});
    end
    $display("Test register rows done");
    // Mid-run reset restores defaults; multi-byte read walks the bank
    rstn = 1'h0;
    repeat (20) @(negedge clk);
    rstn = 1'h1;
    repeat (4) @(negedge clk);
    rd(8'h10, 8);
    for (int i = 0; i < 8; i++) chk(rb[i], rv[i]);
    $display("Test reset values done");
    e = 6'h00;
    for (int r = 0; r < 4; r++) begin
      e = e + 6'(r + 1);
      trk(1'h0, 16'hc001, 1'h1, 2'(r), e);
    end
    trk(1'h0, 16'hc000, 1'h1, 2'h0, e);
    trk(1'h0, 16'hffff, 1'h0, 2'h0, e);
    trk(1'h0, 16'h3fff, 1'h1, 2'h3, e - 6'h04);
    trk(1'h1, 16'h0000, 1'h1, 2'h3, 6'h00);
    e = 6'h00;
    for (int i = 0; i < 16; i++) begin
      e = (e > 6'h3b) ? 6'h3f : e + 6'h04;
      trk(1'h1, 16'hffff, 1'h1, 2'h3, e);
    end
    $display("Test tracking done");
    u_cs_i2c_master.start();
    u_cs_i2c_master.xfer(8'h92, 1'h1, q, k);
    chk({7'h0, k}, 8'h00);
    u_cs_i2c_master.stop();
    rd(8'h12, 1);
    rd(8'hff, 1);
    chk(rb[0], 8'h00);
    $display("Test address and pointer done");
    wr(8'h10, 8'h7f);
    for (int i = 0; i < 4; i++) begin
      repeat (600) @(negedge clk);
      if (i[0]) comp_out2 = 1'h1;
      else comp_out1 = 1'h1;
      @(negedge clk);
      comp_out1 = 1'h0;
      comp_out2 = 1'h0;
    end
    chk({7'h0, power_down}, 8'h00);
    repeat (1150) @(negedge clk);
    chk({7'h0, power_down}, 8'h00);
    repeat (150) @(negedge clk);
    chk({7'h0, power_down}, 8'h01);
    chk({6'h0, offset_dac_on2, offset_dac_on1}, 8'h00);
    rd(8'hff, 1);
    chk({7'h0, power_down}, 8'h00);
    wr(8'h10, 8'h40);
    repeat (1400) @(negedge clk);
    chk({7'h0, power_down}, 8'h00);
    $display("Test inactivity timer done");
    close_out();
  end

  // Watchdog well beyond the expected run of about 80 us
  initial begin
    #300us;
    fails++;
    close_out();
  end
endmodule // tb_top

// *** core/cs_i2c_regs.v ***
/*
  Upper register bank of a two-channel capacitance sensor with its two-wire serial slave:
  inactivity timer register, two offset-DAC registers with auto tracking, serial number
  and identity bytes. Assumes comparator, threshold-mode and average inputs come from
  core logic on clk, and that SCL/SDA are pins resolved outside (SDA open drain).
*/
`include "cs_map.vh"

module cs_i2c_regs #(
  parameter        AW            = 16,
  parameter [31:0] SERIAL_NUMBER = `CS_SERIAL_DEFAULT,
  parameter [7:0]  CHIP_IDENT    = `CS_IDENT_DEFAULT,
  parameter [47:0] UNIT_CYCLES   = `CS_UNIT_CYCLES
) (
  // Clock and control
  input  wire          clk,
  input  wire          rstn,
  input  wire          ce,
  // Serial bus pins
  input  wire          scl_i,
  input  wire          sda_i,
  output wire          sda_o,
  output wire          sda_oe,
  // Core status
  input  wire          comp_out1,
  input  wire          comp_out2,
  input  wire          adaptive_mode,
  input  wire [1:0]    cap_range,
  // Data averages from the converter core
  input  wire [AW-1:0] avg1,
  input  wire          avg1_valid,
  input  wire [AW-1:0] avg2,
  input  wire          avg2_valid,
  // Offset DAC controls
  output wire          offset_dac_on1,
  output wire          offset_dac_on2,
  output wire [5:0]    offset_code1,
  output wire [5:0]    offset_code2,
  // Power state
  output wire          power_down
);

  ////////////////////////////////////////////////////////////////////////////////
  // Constants

  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_ADDR = 7'h02;
  localparam [6:0] ST_PTR  = 7'h04;
  localparam [6:0] ST_WR   = 7'h08;
  localparam [6:0] ST_ACK  = 7'h10;
  localparam [6:0] ST_RD   = 7'h20;
  localparam [6:0] ST_MACK = 7'h40;

  // Tracking limits: three quarters and one quarter of full range
  localparam [AW-1:0] AVG_HI = {2'b11, {(AW-2){1'b0}}};
  localparam [AW-1:0] AVG_LO = {2'b01, {(AW-2){1'b0}}};

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and bus conditions

  wire [1:0] pin_s;
  wire       scl_s = pin_s[1];
  wire       sda_s = pin_s[0];

  cs_sync2 #(
    .W    (2)
  ) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .ce   (ce),
    .d    ({scl_i, sda_i}),
    .q    (pin_s)
  );

  reg scl_d_r;
  reg sda_d_r;

  // Previous synchronised levels for edge finding
  always @(posedge clk) begin
    if (!rstn) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else if (ce) begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  wire scl_rise = scl_s && !scl_d_r;
  wire scl_fall = !scl_s && scl_d_r;
  wire bus_start = scl_s && scl_d_r && sda_d_r && !sda_s;
  wire bus_stop  = scl_s && scl_d_r && !sda_d_r && sda_s;

  ////////////////////////////////////////////////////////////////////////////////
  // State

  reg [6:0] st_r;
  reg [6:0] ack_to_r;
  reg [3:0] bit_r;
  reg [7:0] sh_r;
  reg [7:0] tx_r;
  reg [7:0] ptr_r;
  reg       oe_r;
  reg       wake_r;
  reg       tmr_wr_r;
  reg [7:0] timer_r;
  reg [7:0] dac1_r;
  reg [7:0] dac2_r;
  reg       comp1_d_r;
  reg       comp2_d_r;

  wire      pd;

  ////////////////////////////////////////////////////////////////////////////////
  // Read data for the addressed register

  reg [7:0] rd_data;

  // Unmapped and lower addresses read as zero here; the pointer itself is never readable
  always @* begin
    case (ptr_r)
      `CS_ADDR_TIMER: rd_data = timer_r;
      `CS_ADDR_DAC1:  rd_data = dac1_r;
      `CS_ADDR_DAC2:  rd_data = dac2_r;
      `CS_ADDR_SN0:   rd_data = SERIAL_NUMBER[31:24];
      `CS_ADDR_SN1:   rd_data = SERIAL_NUMBER[23:16];
      `CS_ADDR_SN2:   rd_data = SERIAL_NUMBER[15:8];
      `CS_ADDR_SN3:   rd_data = SERIAL_NUMBER[7:0];
      `CS_ADDR_ID:    rd_data = CHIP_IDENT;
      default:        rd_data = `CS_READ_NONE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Offset tracking

  reg [5:0] step;

  // Step follows the selected capacitive input range
  always @* begin
    case (cap_range)
      2'h0:    step = `CS_STEP_R0;
      2'h1:    step = `CS_STEP_R1;
      2'h2:    step = `CS_STEP_R2;
      default: step = `CS_STEP_R3;
    endcase
  end

  // Saturating step keeps the code inside its linear range
  function [5:0] track;
    input [5:0]    code;
    input [AW-1:0] avg;
    input [5:0]    stp;
    begin
      track = code;
      if (avg > AVG_HI) begin
        track = (code > `CS_CODE_MAX - stp) ? `CS_CODE_MAX : code + stp;
      end else if (avg < AVG_LO) begin
        track = (code < stp) ? `CS_CODE_ZERO : code - stp;
      end
    end
  endfunction

  // Tracking is off in fixed threshold mode and while powered down
  wire trk1 = avg1_valid && dac1_r[`CS_BIT_AUTO] && adaptive_mode && !pd;
  wire trk2 = avg2_valid && dac2_r[`CS_BIT_AUTO] && adaptive_mode && !pd;

  ////////////////////////////////////////////////////////////////////////////////
  // Serial slave and register bank

  wire rx_state = (st_r == ST_ADDR) || (st_r == ST_PTR) || (st_r == ST_WR);
  wire addr_hit = (sh_r[7:1] == `CS_SLAVE_ADDR);
  wire wr_hit   = (st_r == ST_WR) && scl_fall && (bit_r == `CS_BYTE_BITS);

  // A host write takes priority over a tracking step in the same cycle
  always @(posedge clk) begin
    if (!rstn) begin
      st_r      <= ST_IDLE;
      ack_to_r  <= ST_IDLE;
      bit_r     <= `CS_BIT_ZERO;
      sh_r      <= 8'h00;
      tx_r      <= 8'h00;
      ptr_r     <= `CS_ADDR_STATUS;
      oe_r      <= 1'b0;
      wake_r    <= 1'b0;
      tmr_wr_r  <= 1'b0;
      timer_r   <= `CS_RST_TIMER;
      dac1_r    <= `CS_RST_DAC;
      dac2_r    <= `CS_RST_DAC;
      comp1_d_r <= 1'b0;
      comp2_d_r <= 1'b0;
    end else if (ce) begin
      wake_r    <= 1'b0;
      tmr_wr_r  <= 1'b0;
      comp1_d_r <= comp_out1;
      comp2_d_r <= comp_out2;

      // Auto tracking of the offset codes
      if (trk1) begin
        dac1_r[`CS_CODE_MSB:0] <= track(dac1_r[`CS_CODE_MSB:0], avg1, step);
      end
      if (trk2) begin
        dac2_r[`CS_CODE_MSB:0] <= track(dac2_r[`CS_CODE_MSB:0], avg2, step);
      end

      if (bus_start) begin
        // Repeated start behaves exactly as a start
        st_r  <= ST_ADDR;
        bit_r <= `CS_BIT_ZERO;
        oe_r  <= 1'b0;
      end else if (bus_stop) begin
        st_r  <= ST_IDLE;
        oe_r  <= 1'b0;
        ptr_r <= `CS_ADDR_STATUS;
      end else begin
        case (st_r)
          ST_IDLE: begin
            oe_r <= 1'b0;
          end
          ST_ADDR, ST_PTR, ST_WR: begin
            if (scl_rise && bit_r != `CS_BYTE_BITS) begin
              sh_r  <= {sh_r[6:0], sda_s};
              bit_r <= bit_r + 4'h1;
            end else if (scl_fall && bit_r == `CS_BYTE_BITS) begin
              bit_r <= `CS_BIT_ZERO;
              if (st_r == ST_ADDR) begin
                if (addr_hit) begin
                  oe_r     <= 1'b1;
                  st_r     <= ST_ACK;
                  wake_r   <= 1'b1;
                  ack_to_r <= (sh_r[0] == `CS_RW_WRITE) ? ST_PTR : ST_RD;
                end else begin
                  st_r <= ST_IDLE;
                end
              end else if (st_r == ST_PTR) begin
                ptr_r    <= sh_r;
                oe_r     <= 1'b1;
                st_r     <= ST_ACK;
                ack_to_r <= ST_WR;
              end else begin
                // Invalid addresses are acknowledged but not loaded
                ptr_r    <= ptr_r + 8'h01;
                oe_r     <= 1'b1;
                st_r     <= ST_ACK;
                ack_to_r <= ST_WR;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              bit_r <= `CS_BIT_ZERO;
              if (ack_to_r == ST_RD) begin
                tx_r <= rd_data;
                oe_r <= ~rd_data[7];
                st_r <= ST_RD;
              end else begin
                oe_r <= 1'b0;
                st_r <= ack_to_r;
              end
            end
          end
          ST_RD: begin
            if (scl_fall) begin
              if (bit_r == `CS_LAST_BIT) begin
                oe_r <= 1'b0;
                st_r <= ST_MACK;
              end else begin
                bit_r <= bit_r + 4'h1;
                tx_r  <= {tx_r[6:0], 1'b0};
                oe_r  <= ~tx_r[6];
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              if (sda_s) begin
                st_r <= ST_IDLE;                            // No acknowledge keeps the pointer
              end else begin
                ptr_r <= ptr_r + 8'h01;
              end
            end else if (scl_fall) begin
              bit_r <= `CS_BIT_ZERO;
              tx_r  <= rd_data;
              oe_r  <= ~rd_data[7];
              st_r  <= ST_RD;
            end
          end
          default: begin
            st_r <= ST_IDLE;
            oe_r <= 1'b0;
          end
        endcase
      end

      // Register writes from the serial port
      if (wr_hit && !bus_start && !bus_stop) begin
        case (ptr_r)
          `CS_ADDR_TIMER: begin
            timer_r  <= sh_r;
            tmr_wr_r <= 1'b1;
          end
          `CS_ADDR_DAC1: dac1_r <= sh_r;
          `CS_ADDR_DAC2: dac2_r <= sh_r;
          default: begin
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Inactivity timer

  // Restart on a rising comparator output or a rewrite of the timeout field
  wire tmr_restart = (comp_out1 && !comp1_d_r) || (comp_out2 && !comp2_d_r) || tmr_wr_r;

  cs_sleep_timer #(
    .UNIT_CYCLES (UNIT_CYCLES)
  ) u_timer (
    .clk        (clk),
    .rstn       (rstn),
    .ce         (ce),
    .timeout    (timer_r[5:0]),
    .restart    (tmr_restart),
    .wake       (wake_r),
    .power_down (pd)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Open drain: only ever pull low; the serial port stays alive in power-down
  assign sda_o          = 1'b0;
  assign sda_oe         = oe_r;
  assign offset_dac_on1 = dac1_r[`CS_BIT_DAC_ON] && !pd;
  assign offset_dac_on2 = dac2_r[`CS_BIT_DAC_ON] && !pd;
  assign offset_code1   = dac1_r[`CS_CODE_MSB:0];
  assign offset_code2   = dac2_r[`CS_CODE_MSB:0];
  assign power_down     = pd;

endmodule // cs_i2c_regs

// *** core/cs_map.vh ***
/*
  Constants for the capacitance-sensor upper register bank and its serial slave port:
  register addresses, reset values, field positions, bus address and time figures.
  Assumes it is included by bare name from every design file that needs it.
*/
`ifndef CS_MAP_VH
`define CS_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// Register addresses
`define CS_ADDR_STATUS     8'h00
`define CS_ADDR_TIMER      8'h10
`define CS_ADDR_DAC1       8'h11
`define CS_ADDR_DAC2       8'h12
`define CS_ADDR_SN0        8'h13
`define CS_ADDR_SN1        8'h14
`define CS_ADDR_SN2        8'h15
`define CS_ADDR_SN3        8'h16
`define CS_ADDR_ID         8'h17

////////////////////////////////////////////////////////////////////////////////
// Reset values and fields
`define CS_RST_TIMER       8'h40
`define CS_RST_DAC         8'hc0
`define CS_BIT_DAC_ON      7
`define CS_BIT_AUTO        6
`define CS_CODE_MSB        5
`define CS_CODE_MAX        6'h3f
`define CS_CODE_ZERO       6'h00
`define CS_READ_NONE       8'h00

////////////////////////////////////////////////////////////////////////////////
// Serial bus
`define CS_SLAVE_ADDR      7'h48
`define CS_RW_WRITE        1'h0
`define CS_BYTE_BITS       4'h8
`define CS_LAST_BIT        4'h7
`define CS_BIT_ZERO        4'h0

////////////////////////////////////////////////////////////////////////////////
// Offset tracking step per input range (arbitrary plain values)
`define CS_STEP_R0         6'h01
`define CS_STEP_R1         6'h02
`define CS_STEP_R2         6'h03
`define CS_STEP_R3         6'h04

////////////////////////////////////////////////////////////////////////////////
// Inactivity time unit: 4 hours at the 250 MHz core clock
`define CS_UNIT_HOURS      48'h4
`define CS_SEC_PER_HOUR    48'he10
`define CS_CLK_HZ          48'hee6b280
`define CS_UNIT_CYCLES     (`CS_UNIT_HOURS * `CS_SEC_PER_HOUR * `CS_CLK_HZ)

////////////////////////////////////////////////////////////////////////////////
// Identity defaults (values are arbitrary)
`define CS_SERIAL_DEFAULT  32'h01234567
`define CS_IDENT_DEFAULT   8'h5a

`endif

// *** core/cs_sleep_timer.v ***
/*
  Inactivity power-down timer counted in units of four hours.
  Assumes restart and wake are single-cycle pulses on the core clock.
*/
`include "cs_map.vh"

module cs_sleep_timer #(
  parameter [47:0] UNIT_CYCLES = `CS_UNIT_CYCLES
) (
  // Clock and control
  input  wire       clk,
  input  wire       rstn,
  input  wire       ce,
  // Control from the register bank
  input  wire [5:0] timeout,
  input  wire       restart,
  input  wire       wake,
  // State
  output wire       power_down
);

  reg  [47:0] pre_r;
  reg  [5:0]  units_r;
  reg         pd_r;

  wire        armed     = (timeout != `CS_CODE_ZERO);
  wire        unit_tick = (pre_r == UNIT_CYCLES - 48'h1);
  wire        expire    = armed && !pd_r && !restart && unit_tick && (units_r + 6'h01 == timeout);

  // Prescaler gives the slow time base; field counts whole units
  always @(posedge clk) begin
    if (!rstn) begin
      pre_r   <= 48'h0;
      units_r <= 6'h00;
      pd_r    <= 1'b0;
    end else if (ce) begin
      if (!armed || restart || wake || pd_r) begin
        pre_r   <= 48'h0;
        units_r <= 6'h00;
      end else if (unit_tick) begin
        pre_r   <= 48'h0;
        units_r <= units_r + 6'h01;
      end else begin
        pre_r   <= pre_r + 48'h1;
      end
      // Expiry wins over a wake in the same cycle
      if (expire) begin
        pd_r <= 1'b1;
      end else if (wake) begin
        pd_r <= 1'b0;
      end
    end
  end

  assign power_down = pd_r;

endmodule // cs_sleep_timer

// *** core/cs_sync2.v ***
/*
  Two-flop synchroniser for a group of asynchronous inputs.
  Assumes the inputs are pins; only the second stage may be read.
*/
module cs_sync2 #(
  parameter W = 1
) (
  // Clock and control
  input  wire         clk,
  input  wire         rstn,
  input  wire         ce,
  // Data
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);

  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  // First stage feeds only the second stage; resets to idle-high bus level
  always @(posedge clk) begin
    if (!rstn) begin
      meta_r <= {W{1'b1}};
      sync_r <= {W{1'b1}};
    end else if (ce) begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end

  assign q = sync_r;

endmodule // cs_sync2
